// [fsui_framer.v]
// Framed stream user interface: transmit framing and receive deframing on the user clock.
`timescale 1ns/100ps
`default_nettype none
`include "fsui_defs.vh"

// Overview of operation
// - Take a beat only when valid and ready.
// - Valid low mid-frame sends idles for gap.
// - Accepted first beat opens a frame.
// - Byte qualifier counted only on last beat.
// - Start pair precedes first data byte.
// - End pair follows last data or pad.
// - Idles whenever nothing to send.
// - Pad byte appended for odd byte counts.
// - Last two bytes slip to next beat.
// - Ready drops one cycle after last beat.
// - Periodic clock compensation pauses user data.
// - Pause every 5000 clocks, two-byte lanes.
// - Pause lasts six clocks, two-byte lanes.
// - Receive port has no ready, no buffer.
// - Receive valid with first, last with final.
// - Receive byte qualifier from final word count.
// - Receive valid may drop mid-frame.
// - Receiver strips idles, compensation, delimiters.
// - Words striped over lanes and reassembled.
// - Receive last lasts one cycle per frame.
// - Start pair top lane, end pair bottom.
// - Most significant byte and bit first.
module fsui_framer #(
   parameter LANES     = 2,                   // Number of two-byte lanes, at least two.
   parameter CC_PERIOD = `FSUI_CC_PERIOD_2B,  // Cycles between compensation pauses.
   parameter CC_PAUSE  = `FSUI_CC_PAUSE_2B    // Pause length in cycles.
) (
   input  wire                 clk,          // User clock, 20 MHz.
   input  wire                 resetn,       // Asynchronous reset, active low.
   input  wire [16*LANES-1:0]  txData,       // Transmit data word.
   input  wire [2*LANES-1:0]   txKeep,       // Transmit byte qualifier.
   input  wire                 txLast,       // Transmit end of frame.
   input  wire                 txValid,      // Transmit beat valid.
   output wire                 txReady,      // Core accepts a beat.
   output wire [16*LANES-1:0]  txChanData,   // Channel beat toward the lanes.
   output wire [2*LANES-1:0]   txChanCtrl,   // Control flag per channel byte.
   input  wire [16*LANES-1:0]  rxChanData,   // Channel beat from the lanes.
   input  wire [2*LANES-1:0]   rxChanCtrl,   // Control flag per received byte.
   output wire [16*LANES-1:0]  rxData,       // Receive data word.
   output wire [2*LANES-1:0]   rxKeep,       // Receive byte qualifier.
   output wire                 rxLast,       // Receive end of frame.
   output wire                 rxValid       // Receive beat valid.
);

   localparam NB   = 2 * LANES;  // Bytes per word.
   localparam DW   = 8 * NB;     // Bits per word.
   localparam ACCB = 3 * NB;     // Receive accumulator depth in bytes.
   localparam ACCW = 8 * ACCB;   // Receive accumulator width in bits.

   // ==========================================================================
   // Helper functions
   // ==========================================================================
   // Number of set bits in a byte qualifier; contiguous ones are assumed.
   function [7:0] keepCount;
      input [NB-1:0] k;
      integer i;
      begin
         keepCount = 8'h00;
         for (i = 0; i < NB; i = i + 1) begin
            keepCount = keepCount + {7'h00, k[i]};
         end
      end
   endfunction

   // Qualifier for the first cnt bytes in send order, most significant first.
   function [NB-1:0] countToKeep;
      input [7:0] cnt;
      integer i;
      begin
         countToKeep = {NB{1'b0}};
         for (i = 0; i < NB; i = i + 1) begin
            countToKeep[i] = (i + cnt >= NB);
         end
      end
   endfunction

   // ==========================================================================
   // Transmit state
   // ==========================================================================
   reg [DW-1:0]   txChanData_reg;   // Registered channel beat.
   reg [NB-1:0]   txChanCtrl_reg;   // Registered control flags.
   reg [15:0]     carry_reg;        // Two bytes delayed to the next beat.
   reg            inFrame_reg;      // A frame is open.
   reg            tailPend_reg;     // Gap cycle after a last beat is due.
   reg [DW-1:0]   tailData_reg;     // Beat to send in the gap cycle.
   reg [NB-1:0]   tailCtrl_reg;     // Control flags for that beat.
   reg [DW-1:0]   txChanData_next;  // Next channel beat.
   reg [NB-1:0]   txChanCtrl_next;  // Next control flags.
   reg [DW-1:0]   tailData_next;    // Next gap-cycle beat.
   reg [NB-1:0]   tailCtrl_next;    // Next gap-cycle flags.
   reg [8*NB+15:0] seq;             // Prefix followed by the current data word.
   reg [NB+1:0]   seqCtrl;          // Control flags for seq.
   reg [7:0]      kCnt;             // Valid bytes in the last beat.
   wire           ccActive;         // Clock compensation pause in progress.
   wire           accept;           // Beat taken this cycle.
   integer        p;                // Byte position loop index.

   assign txReady    = !tailPend_reg && !ccActive;
   assign accept     = txValid && txReady;
   assign txChanData = txChanData_reg;
   assign txChanCtrl = txChanCtrl_reg;

   // A pending tail goes first; a pause then freezes a cycle, so frames never starve it.
   fsui_cc_timer #(
      .PERIOD (CC_PERIOD),
      .PAUSE  (CC_PAUSE)
   ) ccTimer (
      .clk      (clk),
      .resetn   (resetn),
      .hold     (tailPend_reg),
      .ccActive (ccActive)
   );

   // Build the next channel beat. Byte NB-1 leaves first, so the top lane
   // carries the earliest bytes of each beat.
   always @* begin
      txChanData_next = {NB{`FSUI_CODE_IDLE}};
      txChanCtrl_next = {NB{1'b1}};
      tailData_next   = tailData_reg;
      tailCtrl_next   = tailCtrl_reg;
      kCnt            = keepCount(txKeep);
      seq             = {inFrame_reg ? carry_reg : {`FSUI_CODE_SD1, `FSUI_CODE_SD2}, txData};
      seqCtrl         = {{2{!inFrame_reg}}, {NB{1'b0}}};
      if (tailPend_reg) begin
         txChanData_next = tailData_reg;
         txChanCtrl_next = tailCtrl_reg;
      end else if (ccActive) begin
         txChanData_next = {NB{`FSUI_CODE_CC}};
      end else if (accept && !txLast) begin
         txChanData_next = seq[8*NB+15:16];
         txChanCtrl_next = seqCtrl[NB+1:2];
      end else if (accept) begin
         // Positions past the valid bytes become pad (odd count) or idle.
         for (p = 0; p < NB + 2; p = p + 1) begin
            if (p == kCnt + 2 && kCnt[0]) begin
               seq[8*(NB+1-p) +: 8] = `FSUI_CODE_PAD;
               seqCtrl[NB+1-p]      = 1'b1;
            end else if (p >= kCnt + 2) begin
               seq[8*(NB+1-p) +: 8] = `FSUI_CODE_IDLE;
               seqCtrl[NB+1-p]      = 1'b1;
            end
         end
         txChanData_next = seq[8*NB+15:16];
         txChanCtrl_next = seqCtrl[NB+1:2];
         // Gap beat: slipped bytes in the top lane, end pair in the bottom lane.
         tailData_next = {NB{`FSUI_CODE_IDLE}};
         tailCtrl_next = {NB{1'b1}};
         tailData_next[DW-1 -: 16] = seq[15:0];
         tailCtrl_next[NB-1 -: 2]  = seqCtrl[1:0];
         tailData_next[15:0] = {`FSUI_CODE_ED1, `FSUI_CODE_ED2};
         tailCtrl_next[1:0]  = 2'b11;
      end
   end

   // Transmit registers. Without an accepted beat the carry bytes wait.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         txChanData_reg <= {NB{`FSUI_CODE_IDLE}};
         txChanCtrl_reg <= {NB{1'b1}};
         carry_reg      <= 16'h0000;
         inFrame_reg    <= 1'b0;
         tailPend_reg   <= 1'b0;
         tailData_reg   <= {DW{1'b0}};
         tailCtrl_reg   <= {NB{1'b0}};
      end else begin
         txChanData_reg <= txChanData_next;
         txChanCtrl_reg <= txChanCtrl_next;
         tailData_reg   <= tailData_next;
         tailCtrl_reg   <= tailCtrl_next;
         tailPend_reg   <= accept && txLast;
         if (accept) begin
            carry_reg   <= txData[15:0];
            inFrame_reg <= !txLast;
         end
      end
   end

   // ==========================================================================
   // Receive state
   // ==========================================================================
   // No ready input exists: the user must take every valid beat at once.
   reg [ACCW-1:0] acc_reg;        // Stripped bytes, oldest at the top.
   reg [7:0]      accCnt_reg;     // Bytes held in the accumulator.
   reg            endPend_reg;    // A frame end lies inside the accumulator.
   reg [7:0]      endPos_reg;     // Bytes up to that frame end.
   reg            rxInFrame_reg;  // Between start and end pairs on the channel.
   reg [DW-1:0]   rxData_reg;     // Registered receive word.
   reg [NB-1:0]   rxKeep_reg;     // Registered receive qualifier.
   reg            rxLast_reg;     // Registered receive end of frame.
   reg            rxValid_reg;    // Registered receive valid.
   reg [ACCW-1:0] acc_next;       // Next accumulator contents.
   reg [7:0]      accCnt_next;    // Next byte count.
   reg            endPend_next;   // Next end-pending flag.
   reg [7:0]      endPos_next;    // Next end position.
   reg            rxInFrame_next; // Next in-frame flag.
   reg [7:0]      emit;           // Bytes handed to the user this cycle.
   reg            lastNow;        // This cycle closes a frame.
   integer        b;              // Channel byte index.

   assign rxData  = rxData_reg;
   assign rxKeep  = rxKeep_reg;
   assign rxLast  = rxLast_reg;
   assign rxValid = rxValid_reg;

   // Emit from the accumulator, then left-align new data bytes behind what stays.
   always @* begin
      lastNow = endPend_reg && (endPos_reg <= NB);
      if (endPend_reg) begin
         emit = (endPos_reg < NB) ? endPos_reg : NB[7:0];
      end else begin
         emit = (accCnt_reg >= NB) ? NB[7:0] : 8'h00;
      end
      acc_next       = acc_reg << (8 * emit);
      accCnt_next    = accCnt_reg - emit;
      endPend_next   = endPend_reg && !lastNow;
      endPos_next    = endPend_next ? endPos_reg - emit : 8'h00;
      rxInFrame_next = rxInFrame_reg;
      for (b = NB - 1; b >= 0; b = b - 1) begin
         if (rxChanCtrl[b]) begin
            // Control bytes never reach the user.
            if (b[0] && rxChanData[8*b +: 8] == `FSUI_CODE_SD1) begin
               rxInFrame_next = 1'b1;
            end else if (b[0] && rxChanData[8*b +: 8] == `FSUI_CODE_ED1 && rxInFrame_next) begin
               rxInFrame_next = 1'b0;
               endPend_next   = 1'b1;
               endPos_next    = accCnt_next;
            end
         end else if (rxInFrame_next && accCnt_next < ACCB) begin
            acc_next[ACCW-1-8*accCnt_next -: 8] = rxChanData[8*b +: 8];
            accCnt_next = accCnt_next + 8'h01;
         end
      end
   end

   // Receive registers; output word is the top of the accumulator.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         acc_reg       <= {ACCW{1'b0}};
         accCnt_reg    <= 8'h00;
         endPend_reg   <= 1'b0;
         endPos_reg    <= 8'h00;
         rxInFrame_reg <= 1'b0;
         rxData_reg    <= {DW{1'b0}};
         rxKeep_reg    <= {NB{1'b0}};
         rxLast_reg    <= 1'b0;
         rxValid_reg   <= 1'b0;
      end else begin
         acc_reg       <= acc_next;
         accCnt_reg    <= accCnt_next;
         endPend_reg   <= endPend_next;
         endPos_reg    <= endPos_next;
         rxInFrame_reg <= rxInFrame_next;
         rxData_reg    <= acc_reg[ACCW-1 -: DW];
         rxValid_reg   <= (emit != 8'h00) || lastNow;
         rxLast_reg    <= lastNow;
         rxKeep_reg    <= lastNow ? countToKeep(emit) : {NB{1'b1}};
      end
   end

endmodule
`default_nettype wire

// [fsui_defs.vh]
// Constants shared by the framed stream user interface: control codes and timing counts.
`ifndef FSUI_DEFS_VH
`define FSUI_DEFS_VH

// ==========================================================================
// Control code bytes, sent with their control flag set
// ==========================================================================
`define FSUI_CODE_SD1    8'h5C   // First byte of the start_delimiter_pair.
`define FSUI_CODE_SD2    8'hFB   // Second byte of the start_delimiter_pair.
`define FSUI_CODE_ED1    8'hFD   // First byte of the end_delimiter_pair.
`define FSUI_CODE_ED2    8'hFE   // Second byte of the end_delimiter_pair.
`define FSUI_CODE_IDLE   8'hBC   // Idle filler.
`define FSUI_CODE_PAD    8'h9C   // Fill character for odd-length frames.
`define FSUI_CODE_CC     8'hF7   // Clock compensation character.

// ==========================================================================
// Clock compensation timing, in user clock cycles
// ==========================================================================
`define FSUI_CC_PERIOD_2B  5000  // Interval for two-byte lanes.
`define FSUI_CC_PERIOD_4B  2500  // Interval for four-byte lanes.
`define FSUI_CC_PAUSE_2B   6     // Suspension for two-byte lanes.
`define FSUI_CC_PAUSE_4B   3     // Suspension for four-byte lanes.

`endif

// [fsui_cc_timer.v]
// Clock compensation scheduler: periodic request and a fixed-length pause window.
`timescale 1ns/100ps
`default_nettype none

module fsui_cc_timer #(
   parameter PERIOD = 5000,  // Cycles between compensation pauses.
   parameter PAUSE  = 6      // Length of each pause in cycles.
) (
   input  wire clk,          // User clock.
   input  wire resetn,       // Asynchronous reset, active low.
   input  wire hold,         // Defer the pause start while a frame tail is pending.
   output wire ccActive      // High during each compensation pause.
);

   reg [15:0] periodCnt_reg;  // Free-running interval counter.
   reg [7:0]  pauseCnt_reg;   // Cycles left in the current pause.
   reg        due_reg;        // Interval expired, pause not yet started.
   reg        active_reg;     // Pause in progress.

   assign ccActive = active_reg;

   // ==========================================================================
   // Interval counting and pause sequencing
   // ==========================================================================
   // The interval runs free so that a deferred start does not stretch the period.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         periodCnt_reg <= 16'h0000;
         pauseCnt_reg  <= 8'h00;
         due_reg       <= 1'b0;
         active_reg    <= 1'b0;
      end else begin
         if (periodCnt_reg == PERIOD[15:0] - 16'h0001) begin
            periodCnt_reg <= 16'h0000;
            due_reg       <= 1'b1;
         end else begin
            periodCnt_reg <= periodCnt_reg + 16'h0001;
         end
         if (active_reg && !hold) begin
            if (pauseCnt_reg == 8'h00) begin
               active_reg <= 1'b0;
            end else begin
               pauseCnt_reg <= pauseCnt_reg - 8'h01;
            end
         end else if (!active_reg && due_reg && !hold) begin
            active_reg   <= 1'b1;
            pauseCnt_reg <= PAUSE[7:0] - 8'h01;
            due_reg      <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// [fsui_user_sink.sv]
// Receive-side user model for the framer bench.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// User sink: it has no way to stall, so each valid beat is stored at once.
module fsui_user_sink #(
   parameter LANES = 2  // Lanes of two bytes.
) (
   input wire logic                clk,     // User clock.
   input wire logic [16*LANES-1:0] rxData,  // Receive word.
   input wire logic [2*LANES-1:0]  rxKeep,  // Receive qualifier.
   input wire logic                rxLast,  // Receive end of frame.
   input wire logic                rxValid  // Receive beat valid.
);
   logic [18*LANES:0] beats[$];  // Stored {last, keep, data}, read by the bench.
   // Take every offered beat in its own cycle; a missed beat is lost for good.
   always @(posedge clk) begin
      if (rxValid === 1'b1) begin
         beats.push_back({rxLast, rxKeep, rxData});
      end
   end
endmodule
`default_nettype wire

// [fsui_framer_chk.sv]
// Port checker for the framer, bound beneath its top module.
`timescale 1ns/100ps
`default_nettype none
`include "fsui_defs.vh"
// ==========================================================================
// Checker of transmit framing, compensation pauses and receive strobes.
module fsui_framer_chk #(
   parameter LANES     = 2,    // Lanes of two bytes.
   parameter CC_PERIOD = 5000  // Cycles between pauses.
) (
   input wire logic                clk,         // User clock.
   input wire logic                resetn,      // Reset, active low.
   input wire logic [16*LANES-1:0] txData,      // Transmit word.
   input wire logic [2*LANES-1:0]  txKeep,      // Transmit qualifier.
   input wire logic                txLast,      // Transmit end of frame.
   input wire logic                txValid,     // Transmit beat valid.
   input wire logic                txReady,     // Beat accepted.
   input wire logic [16*LANES-1:0] txChanData,  // Channel beat.
   input wire logic [2*LANES-1:0]  txChanCtrl,  // Channel control flags.
   input wire logic [2*LANES-1:0]  rxKeep,      // Receive qualifier.
   input wire logic                rxLast,      // Receive end of frame.
   input wire logic                rxValid      // Receive beat valid.
);
   localparam DW = 16*LANES;                 // Word width.
   wire acc = txValid && txReady;            // A beat is taken.
   wire full = !txLast || (&txKeep);         // Word has no pad or idle in it.
   wire isCc = (txChanData == {2*LANES{`FSUI_CODE_CC}}) && (&txChanCtrl);
   reg        inFrame_reg;                   // A frame is open.
   reg        prevCc_reg;                    // Compensation beat a cycle ago.
   reg        seen_reg;                      // One pause has started already.
   reg [15:0] low_reg;                       // Low lane of the last taken word.
   reg [15:0] cnt_reg;                       // Cycles since the last pause start.
   wire ccStart = isCc && !prevCc_reg;       // A pause shows on the channel.
   // ==========================================================================
   // Helper state; pause starts are seen on the channel, so a deferred pause is still counted.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         inFrame_reg <= 1'b0;
         prevCc_reg  <= 1'b0;
         seen_reg    <= 1'b0;
         low_reg     <= 16'h0000;
         cnt_reg     <= 16'h0000;
      end else begin
         if (acc) begin
            inFrame_reg <= !txLast;
            low_reg     <= txData[15:0];
         end
         prevCc_reg <= isCc;
         seen_reg   <= seen_reg || ccStart;
         cnt_reg    <= ccStart ? 16'h0000 : cnt_reg + 16'h0001;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_gap;
      acc && txLast |=> !txReady ##1 (txChanData[15:0] == {`FSUI_CODE_ED1, `FSUI_CODE_ED2}) && (&txChanCtrl[1:0]);
   endproperty
   a_gap: assert property (p_gap) else $error("ready gap or end pair wrong");
   property p_start;
      acc && !inFrame_reg && full |=> (txChanData[DW-1:DW-16] == {`FSUI_CODE_SD1, `FSUI_CODE_SD2})
         && (&txChanCtrl[2*LANES-1 -: 2]) && (txChanData[15:0] == $past(txData[DW-1:DW-16]));
   endproperty
   a_start: assert property (p_start) else $error("start pair wrong");
   property p_body;
      acc && inFrame_reg && full |=> (txChanData[DW-1:DW-16] == $past(low_reg))
         && (txChanData[15:0] == $past(txData[DW-1:DW-16])) && (txChanCtrl == '0);
   endproperty
   a_body: assert property (p_body) else $error("data slip wrong");
   property p_idle;
      !acc && txReady |=> (txChanData[15:0] == {`FSUI_CODE_IDLE, `FSUI_CODE_IDLE}) && (&txChanCtrl[1:0]);
   endproperty
   a_idle: assert property (p_idle) else $error("idle missing");
   property p_ccwin;
      ccStart |-> isCc[*6] ##1 !isCc;
   endproperty
   a_ccwin: assert property (p_ccwin) else $error("pause length wrong");
   property p_ccready;
      isCc |-> !$past(txReady);
   endproperty
   a_ccready: assert property (p_ccready) else $error("ready high in pause");
   property p_ccper;
      ccStart && seen_reg |-> (cnt_reg >= CC_PERIOD - 4) && (cnt_reg <= CC_PERIOD + 3);
   endproperty
   a_ccper: assert property (p_ccper) else $error("pause period wrong");
   property p_rxlast;
      rxLast |-> rxValid ##1 !rxLast;
   endproperty
   a_rxlast: assert property (p_rxlast) else $error("receive last wrong");
   property p_rxkeep;
      rxValid && !rxLast |-> (&rxKeep);
   endproperty
   a_rxkeep: assert property (p_rxkeep) else $error("receive keep wrong");
   c_frame: cover property (acc && txLast);
   c_cc: cover property (ccStart && seen_reg);
   c_rx: cover property (rxLast);
endmodule
bind fsui_framer fsui_framer_chk #(.LANES(LANES), .CC_PERIOD(CC_PERIOD)) i_fsui_framer_chk (
   .clk(clk), .resetn(resetn), .txData(txData), .txKeep(txKeep), .txLast(txLast), .txValid(txValid),
   .txReady(txReady), .txChanData(txChanData), .txChanCtrl(txChanCtrl), .rxKeep(rxKeep),
   .rxLast(rxLast), .rxValid(rxValid));
`default_nettype wire

// [fsui_framer_tb_top.sv]
// Self-checking bench for the framer with the channel looped back.
`timescale 1ns/100ps
`default_nettype none
`include "fsui_defs.vh"
// ==========================================================================
// Bench top: drives the transmit port, watches the channel, judges receive beats.
module fsui_framer_tb_top;
   localparam CCP = 400;                      // Shortened compensation period.
   logic        clk = 1'b0;                   // User clock, 50 ns.
   logic        resetn = 1'b0;                // Reset, active low.
   logic [31:0] txData = 32'h0;               // Transmit word.
   logic [3:0]  txKeep = 4'h0;                // Transmit qualifier.
   logic        txLast = 1'b0;                // Transmit end of frame.
   logic        txValid = 1'b0;               // Transmit beat valid.
   logic [31:0] rxChanData = {4{`FSUI_CODE_IDLE}};  // Looped channel beat.
   logic [3:0]  rxChanCtrl = 4'hF;            // Looped control flags.
   wire         txReady, rxLast, rxValid;     // Design strobes.
   wire  [31:0] txChanData, rxData;           // Design words.
   wire  [3:0]  txChanCtrl, rxKeep;           // Design flags.
   logic [36:0] expW[$], expM[$];             // Expected receive beats and masks.
   logic        ccPrev = 1'b0;                // Compensation beat seen last cycle.
   int nFail = 0, checksDone = 0, cycles = 0, run = 0, lastRun = 0, ccAt = 0, ccGap = 0, nCc = 0;
   wire isCc = (txChanData === {4{`FSUI_CODE_CC}}) && (txChanCtrl === 4'hF);
   always #25 clk = ~clk;
   fsui_framer #(.LANES(2), .CC_PERIOD(CCP), .CC_PAUSE(`FSUI_CC_PAUSE_2B)) i_fsui_framer (
      .clk(clk), .resetn(resetn), .txData(txData), .txKeep(txKeep), .txLast(txLast), .txValid(txValid),
      .txReady(txReady), .txChanData(txChanData), .txChanCtrl(txChanCtrl), .rxChanData(rxChanData),
      .rxChanCtrl(rxChanCtrl), .rxData(rxData), .rxKeep(rxKeep), .rxLast(rxLast), .rxValid(rxValid));
   fsui_user_sink #(.LANES(2)) i_fsui_user_sink (
      .clk(clk), .rxData(rxData), .rxKeep(rxKeep), .rxLast(rxLast), .rxValid(rxValid));
   // Loop the channel back a cycle late, as a far lane would.
   always @(posedge clk) begin
      rxChanData <= txChanData;
      rxChanCtrl <= txChanCtrl;
   end
   // Measure pause lengths and spacing; the cycle ceiling stops a hung run.
   always @(negedge clk) begin
      cycles++;
      if (isCc && !ccPrev) begin
         ccGap = cycles - ccAt;
         ccAt = cycles;
         nCc++;
      end
      run = isCc ? run + 1 : 0;
      if (run != 0) lastRun = run;
      ccPrev = isCc;
      if (cycles == 4000) begin
         nFail++;
         report_and_stop();
      end
   end
   task report_and_stop();
      if (nFail == 0 && checksDone > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task check(input logic [36:0] seen, input logic [36:0] exp);
      checksDone++;
      if (seen !== exp) begin
         nFail++;
         $display("ERROR %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // Present a beat at a rising edge; it stays put until taken.
   task drive(input logic [31:0] d, input logic [3:0] k, input logic l);
      txData <= d;
      txKeep <= k;
      txLast <= l;
      txValid <= 1'b1;
   endtask
   // From a falling edge, wait for ready; the beat goes at the next rising edge.
   task take();
      int i;
      i = 0;
      while (txReady !== 1'b1 && i < 20) begin
         @(negedge clk);
         i++;
      end
      check(txReady, 1'b1);
      @(posedge clk);
   endtask
   // Expect a receive beat holding the first k bytes of d.
   task expect_beat(input logic [31:0] d, input int k, input logic l);
      logic [3:0] kp;
      kp = 4'hF << (4 - k);
      expW.push_back({l, l ? kp : 4'h0, d & ~(32'hFFFFFFFF >> (8 * k))});
      expM.push_back({1'b1, l ? 4'hF : 4'h0, ~(32'hFFFFFFFF >> (8 * k))});
   endtask
   task drain();
      logic [36:0] m;
      repeat (8) @(negedge clk);
      check(i_fsui_user_sink.beats.size(), expW.size());
      while (expW.size() > 0 && i_fsui_user_sink.beats.size() > 0) begin
         m = expM.pop_front();
         check(i_fsui_user_sink.beats.pop_front() & m, expW.pop_front());
      end
      expW.delete();
      expM.delete();
      i_fsui_user_sink.beats.delete();
   endtask
   // Two frames back to back; the second waits through the gap and goes once.
   task test_back_to_back();
      @(posedge clk);
      drive(32'hA0A1A2A3, 4'h1, 1'b0);
      @(negedge clk);
      take();
      drive(32'hB0B1B2B3, 4'hF, 1'b1);
      @(negedge clk);
      check({txChanCtrl, txChanData}, {4'hC, `FSUI_CODE_SD1, `FSUI_CODE_SD2, 16'hA0A1});
      take();
      drive(32'hC0C1C2C3, 4'hF, 1'b1);
      @(negedge clk);
      check({txReady, txChanCtrl, txChanData}, {1'b0, 4'h0, 32'hA2A3B0B1});
      @(negedge clk);
      check({txReady, txChanCtrl, txChanData}, {5'h13, 16'hB2B3, `FSUI_CODE_ED1, `FSUI_CODE_ED2});
      take();
      txValid <= 1'b0;
      expect_beat(32'hA0A1A2A3, 4, 1'b0);
      expect_beat(32'hB0B1B2B3, 4, 1'b1);
      expect_beat(32'hC0C1C2C3, 4, 1'b1);
      drain();
   endtask
   // One-word frames of one to four bytes: pad for odd counts, idles after.
   task test_pad_lengths();
      logic [7:0] b[4];
      logic       c[4];
      for (int k = 1; k <= 4; k++) begin
         for (int i = 0; i < 4; i++) begin
            b[i] = (i < k) ? 8'hD0 + i : ((i == k && k % 2 == 1) ? `FSUI_CODE_PAD : `FSUI_CODE_IDLE);
            c[i] = (i >= k);
         end
         @(posedge clk);
         drive(32'hD0D1D2D3, 4'hF << (4 - k), 1'b1);
         @(negedge clk);
         take();
         txValid <= 1'b0;
         @(negedge clk);
         check({txChanCtrl, txChanData}, {2'b11, c[0], c[1], `FSUI_CODE_SD1, `FSUI_CODE_SD2, b[0], b[1]});
         @(negedge clk);
         check({txChanCtrl, txChanData}, {c[2], c[3], 2'b11, b[2], b[3], `FSUI_CODE_ED1, `FSUI_CODE_ED2});
         expect_beat(32'hD0D1D2D3, k, 1'b1);
         drain();
      end
   endtask
   // Junk outside a frame, then a frame that stalls between its words.
   task test_stall();
      @(posedge clk);
      txData <= 32'hEEEEEEEE;
      repeat (3) @(posedge clk);
      drive(32'hE0E1E2E3, 4'hF, 1'b0);
      @(negedge clk);
      take();
      txValid <= 1'b0;
      repeat (3) @(negedge clk);
      check({txChanCtrl[1:0], txChanData[15:0]}, {2'b11, `FSUI_CODE_IDLE, `FSUI_CODE_IDLE});
      @(posedge clk);
      drive(32'hF0F1F2F3, 4'hF, 1'b1);
      @(negedge clk);
      take();
      txValid <= 1'b0;
      expect_beat(32'hE0E1E2E3, 4, 1'b0);
      expect_beat(32'hF0F1F2F3, 4, 1'b1);
      drain();
   endtask
   // Stream frames across a pause; data must survive and the pause must keep time.
   task test_compensation();
      int j;
      j = 0;
      while (nCc < 1 && cycles < 3000) @(negedge clk);
      @(posedge clk);
      while (nCc < 2 && j < 200) begin
         drive(32'h12340000 + j, 4'hF, 1'b0);
         @(negedge clk);
         take();
         drive(32'h56780000 + j, 4'hF, 1'b1);
         @(negedge clk);
         take();
         expect_beat(32'h12340000 + j, 4, 1'b0);
         expect_beat(32'h56780000 + j, 4, 1'b1);
         j++;
      end
      txValid <= 1'b0;
      drain();
      check(lastRun, `FSUI_CC_PAUSE_2B);
      check(ccGap, CCP);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      test_back_to_back();
      test_pad_lengths();
      test_stall();
      test_compensation();
      report_and_stop();
   end
endmodule
`default_nettype wire
